// ### rtl/monitor_regs.svh
// register offsets, field positions, reset values and counts of the monitor post-processor
`ifndef MONITOR_REGS_SVH
`define MONITOR_REGS_SVH

// ****************************************************************
// global registers (byte addresses)
// ****************************************************************
`define OFS_CONFIG          14'h0000
`define OFS_INT_STATUS      14'h0004
`define OFS_INT_ENABLE      14'h0008
`define OFS_TEMP_RESULT     14'h000c
`define OFS_DIE_UPPER       14'h0010
`define OFS_DIE_LOWER       14'h0014
`define OFS_OVH_UPPER       14'h0018
`define OFS_OVH_LOWER       14'h001c
`define OFS_TEMP_PEAK_HIGH  14'h0020
`define OFS_TEMP_PEAK_LOW   14'h0024
`define OFS_ALARM_STATE     14'h0028

// ****************************************************************
// per-channel banks, index in address bits 9:2
// ****************************************************************
`define BANK_RESULT         4'h4
`define BANK_UPPER          4'h5
`define BANK_LOWER          4'h6
`define BANK_PEAK_HIGH      4'h7
`define BANK_PEAK_LOW       4'h8

// per-channel bit vectors, five words each, word in address bits 4:2
`define VEC_AVG_ENABLE      9'h120
`define VEC_ALARM_ENABLE    9'h121
`define VEC_ALARM_FLAGS     9'h122
`define VEC_PEAK_CLEAR      9'h123

// ****************************************************************
// fields
// ****************************************************************
`define CFG_LEVEL_LSB       0
`define CFG_OVH_SHUT_BIT    4
`define ISR_DIE_BIT         0
`define ISR_OVH_BIT         1
`define ISR_VOLT_BIT        2

// ****************************************************************
// sizes and reset values
// ****************************************************************
`define NUM_CHANNELS        160
`define NUM_VEC_WORDS       5
`define TEMP_AVG_LEVEL      2'h2
`define VOLT_UPPER_RESET    19'h7ffff
`define VOLT_LOWER_RESET    19'h00000
`define DIE_UPPER_RESET     16'h2800
`define DIE_LOWER_RESET     16'h2580
`define OVH_UPPER_RESET     16'h3200
`define OVH_LOWER_RESET     16'h2d00

`endif

// ### rtl/monitor_pkg.sv
// types shared by the monitor post-processor modules
package monitor_pkg;
  typedef logic        [18:0] volt_t;
  typedef logic signed [15:0] temp_t;
  typedef logic signed [19:0] wide_t;
  typedef logic signed [23:0] acc_t;
  // averaging level, number of samples per sequence
  typedef enum logic [1:0] {
    AVG2  = 2'b00,
    AVG4  = 2'b01,
    AVG8  = 2'b10,
    AVG16 = 2'b11
  } avg_level_t;
endpackage : monitor_pkg

// ### rtl/avg_step.sv
// one accumulation step of a power-of-two averaging sequence
`timescale 1ns/1ps
module avg_step
  import monitor_pkg::*;
(
  // running state of the channel
  input  wire acc_t       accIn,
  input  wire logic [3:0] cntIn,
  input  wire avg_level_t level,
  // new sample
  input  wire wide_t      sample,
  // next state and result
  output acc_t            accNext,
  output logic [3:0]      cntNext,
  output logic            done,
  output wide_t           average
);
  acc_t       sum;
  logic [3:0] lastIdx;

  // sum of the sequence, divided by a right shift
  always_comb begin
    sum = accIn + {{4{sample[19]}}, sample};
    case (level)
      AVG2:    lastIdx = 4'h1;
      AVG4:    lastIdx = 4'h3;
      AVG8:    lastIdx = 4'h7;
      default: lastIdx = 4'hf;
    endcase
    // >= so a level lowered mid-sequence closes the sequence at once
    done    = (cntIn >= lastIdx);
    average = wide_t'(sum >>> (32'(level) + 1));
    accNext = done ? '0 : sum;
    cntNext = done ? 4'h0 : cntIn + 4'h1;
  end
endmodule : avg_step

// ### rtl/monitor_channel_postprocess.sv
// post-conversion averaging, peak tracking and alarms of the system monitor
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "monitor_regs.svh"

// Functional notes
// - one shared averaging level: 2,4,8,16
// - averaging enable per channel, independent
// - averaged channel result written once per sequence
// - tracking and alarms of averaged channels see only averaged values
// - temperature always averaged over eight samples
// - per channel highest and lowest value kept
// - averaged channels track peaks from averages only
// - software clears one channel's peaks alone
// - up to 160 voltage alarms
// - window alarm above upper or below lower
// - per channel thresholds, alarm enable, configuration
// - sticky alarm flags with interrupt enables
// - temperature hysteresis: set above, clear below
// - temperature alarms always on, in status
// - die and overheat alarms, own thresholds
// - overheat with shutdown enabled signals controller
// - controller reboots, holds until temperature recovers
// - temperature signed, low 16 bits, 7 fraction
// - supply reading in low 19 bits, unsigned
module monitor_channel_postprocess
  import monitor_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [13:0] avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  // voltage sample stream
  input  wire logic        sampleValid,
  input  wire logic [7:0]  sampleChannel,
  input  wire logic [18:0] sampleData,
  // temperature sample stream
  input  wire logic        tempValid,
  input  wire logic [15:0] tempData,
  // to the platform controller and the system
  output logic             overheatToPmc,
  output logic             alarmIrq
);
  localparam int NCH = `NUM_CHANNELS;

  // ****************************************************************
  // storage
  // ****************************************************************
  volt_t      result_q   [NCH];
  volt_t      upper_q    [NCH];
  volt_t      lower_q    [NCH];
  volt_t      peakHigh_q [NCH];
  volt_t      peakLow_q  [NCH];
  acc_t       acc_q      [NCH];
  logic [3:0] cnt_q      [NCH];
  logic [NCH-1:0] avgEnable_q, alarmEnable_q, alarmFlags_q, peakLoaded_q;
  avg_level_t level_q;
  logic       shutdownEn_q;
  logic [2:0] intEnable_q;
  logic [1:0] intSticky_q;
  temp_t      tempResult_q, tempPeakHigh_q, tempPeakLow_q;
  temp_t      dieUpper_q, dieLower_q, ovhUpper_q, ovhLower_q;
  logic       tempLoaded_q, dieAlarm_q, ovhAlarm_q;
  acc_t       tempAcc_q;
  logic [3:0] tempCnt_q;
  logic       readPending_q;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic       wrFull, rdTake, bankHit, vecHit;
  logic [7:0] wrIdx;
  logic [2:0] wrWord;
  logic [3:0] bank;
  logic [8:0] vecSel;

  assign bank   = avsAddress[13:10];
  assign wrIdx  = avsAddress[9:2];
  assign wrWord = avsAddress[4:2];
  assign vecSel = avsAddress[13:5];
  assign bankHit = (wrIdx < 8'(NCH)) && (bank >= `BANK_RESULT) && (bank <= `BANK_PEAK_LOW);
  assign vecHit  = (wrWord < 3'(`NUM_VEC_WORDS)) && (vecSel >= `VEC_AVG_ENABLE)
                   && (vecSel <= `VEC_PEAK_CLEAR);
  // partial-word writes are ignored, every register is a whole word
  assign wrFull = avsWrite && (avsByteenable == 4'hf) && (avsAddress[1:0] == 2'b00);
  // reads take one wait state, writes none
  assign rdTake = avsRead && !readPending_q;
  assign avsWaitrequest = avsRead && !readPending_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      readPending_q <= 1'b0;
    end else begin
      readPending_q <= rdTake;
    end
  end

  // ****************************************************************
  // voltage averaging path
  // ****************************************************************
  logic  chValid, vDone, vValid, vAlarmNow;
  acc_t  vAccNext;
  logic [3:0] vCntNext;
  wide_t vAvg;
  volt_t vValue;
  logic [7:0] ch;

  assign ch      = sampleChannel;
  assign chValid = sampleValid && (ch < 8'(NCH));

  avg_step voltAvg (
    .accIn   (acc_q[ch]),
    .cntIn   (cnt_q[ch]),
    .level   (level_q),
    .sample  ({1'b0, sampleData}),
    .accNext (vAccNext),
    .cntNext (vCntNext),
    .done    (vDone),
    .average (vAvg)
  );

  // averaged channels yield a value only when the sequence completes
  assign vValid = chValid && (!avgEnable_q[ch] || vDone);
  assign vValue = avgEnable_q[ch] ? vAvg[18:0] : sampleData;
  assign vAlarmNow = (vValue > upper_q[ch]) || (vValue < lower_q[ch]);

  // accumulators advance only for channels with averaging on
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NCH; i++) begin
        acc_q[i] <= '0;
        cnt_q[i] <= 4'h0;
      end
    end else if (chValid && avgEnable_q[ch]) begin
      acc_q[ch] <= vAccNext;
      cnt_q[ch] <= vCntNext;
    end
  end

  // results and peaks; unloaded peaks take the value outright
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NCH; i++) begin
        result_q[i]   <= '0;
        peakHigh_q[i] <= '0;
        peakLow_q[i]  <= '0;
      end
    end else if (vValid) begin
      result_q[ch] <= vValue;
      if (!peakLoaded_q[ch] || (vValue > peakHigh_q[ch])) begin
        peakHigh_q[ch] <= vValue;
      end
      if (!peakLoaded_q[ch] || (vValue < peakLow_q[ch])) begin
        peakLow_q[ch] <= vValue;
      end
    end
  end

  // thresholds are written by software only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NCH; i++) begin
        upper_q[i] <= `VOLT_UPPER_RESET;
        lower_q[i] <= `VOLT_LOWER_RESET;
      end
    end else if (wrFull && bankHit) begin
      if (bank == `BANK_UPPER) begin
        upper_q[wrIdx] <= avsWritedata[18:0];
      end else if (bank == `BANK_LOWER) begin
        lower_q[wrIdx] <= avsWritedata[18:0];
      end
    end
  end

  // ****************************************************************
  // per-channel control and flag bits
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gChan
      logic vecWr;
      logic hit;
      assign vecWr = wrFull && vecHit && (wrWord == 3'(g / 32));
      assign hit   = vValid && (ch == 8'(g));
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          avgEnable_q[g]   <= 1'b0;
          alarmEnable_q[g] <= 1'b0;
          alarmFlags_q[g]  <= 1'b0;
          peakLoaded_q[g]  <= 1'b0;
        end else begin
          if (vecWr && (vecSel == `VEC_AVG_ENABLE)) begin
            avgEnable_q[g] <= avsWritedata[g % 32];
          end
          if (vecWr && (vecSel == `VEC_ALARM_ENABLE)) begin
            alarmEnable_q[g] <= avsWritedata[g % 32];
          end
          // a new alarm in the clearing cycle survives the clear
          if (hit && vAlarmNow && alarmEnable_q[g]) begin
            alarmFlags_q[g] <= 1'b1;
          end else if (vecWr && (vecSel == `VEC_ALARM_FLAGS) && avsWritedata[g % 32]) begin
            alarmFlags_q[g] <= 1'b0;
          end
          // a value landing with the clear cancels it; the peaks only compare against the value
          if (hit) begin
            peakLoaded_q[g] <= 1'b1;
          end else if (vecWr && (vecSel == `VEC_PEAK_CLEAR) && avsWritedata[g % 32]) begin
            peakLoaded_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // temperature path
  // ****************************************************************
  logic  tDone, tValid;
  acc_t  tAccNext;
  logic [3:0] tCntNext;
  wide_t tAvg;
  temp_t tValue;

  avg_step tempAvg (
    .accIn   (tempAcc_q),
    .cntIn   (tempCnt_q),
    .level   (avg_level_t'(`TEMP_AVG_LEVEL)),
    .sample  ({{4{tempData[15]}}, tempData}),
    .accNext (tAccNext),
    .cntNext (tCntNext),
    .done    (tDone),
    .average (tAvg)
  );

  assign tValid = tempValid && tDone;
  assign tValue = tAvg[15:0];

  // temperature accumulator, result and peaks
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tempAcc_q      <= '0;
      tempCnt_q      <= 4'h0;
      tempResult_q   <= '0;
      tempPeakHigh_q <= '0;
      tempPeakLow_q  <= '0;
      tempLoaded_q   <= 1'b0;
    end else if (tempValid) begin
      tempAcc_q <= tAccNext;
      tempCnt_q <= tCntNext;
      if (tValid) begin
        tempResult_q <= tValue;
        tempLoaded_q <= 1'b1;
        if (!tempLoaded_q || (tValue > tempPeakHigh_q)) begin
          tempPeakHigh_q <= tValue;
        end
        if (!tempLoaded_q || (tValue < tempPeakLow_q)) begin
          tempPeakLow_q <= tValue;
        end
      end
    end
  end

  // hysteresis alarms: hold between the two thresholds
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dieAlarm_q <= 1'b0;
      ovhAlarm_q <= 1'b0;
    end else if (tValid) begin
      if (tValue > dieUpper_q) begin
        dieAlarm_q <= 1'b1;
      end else if (tValue < dieLower_q) begin
        dieAlarm_q <= 1'b0;
      end
      if (tValue > ovhUpper_q) begin
        ovhAlarm_q <= 1'b1;
      end else if (tValue < ovhLower_q) begin
        ovhAlarm_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // global registers
  // ****************************************************************
  logic dieRise, ovhRise;
  assign dieRise = tValid && (tValue > dieUpper_q) && !dieAlarm_q;
  assign ovhRise = tValid && (tValue > ovhUpper_q) && !ovhAlarm_q;

  // configuration, enables and temperature thresholds
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q      <= AVG2;
      shutdownEn_q <= 1'b0;
      intEnable_q  <= 3'h0;
      dieUpper_q   <= `DIE_UPPER_RESET;
      dieLower_q   <= `DIE_LOWER_RESET;
      ovhUpper_q   <= `OVH_UPPER_RESET;
      ovhLower_q   <= `OVH_LOWER_RESET;
    end else if (wrFull) begin
      if (avsAddress == `OFS_CONFIG) begin
        level_q      <= avg_level_t'(avsWritedata[`CFG_LEVEL_LSB +: 2]);
        shutdownEn_q <= avsWritedata[`CFG_OVH_SHUT_BIT];
      end else if (avsAddress == `OFS_INT_ENABLE) begin
        intEnable_q <= avsWritedata[2:0];
      end else if (avsAddress == `OFS_DIE_UPPER) begin
        dieUpper_q <= avsWritedata[15:0];
      end else if (avsAddress == `OFS_DIE_LOWER) begin
        dieLower_q <= avsWritedata[15:0];
      end else if (avsAddress == `OFS_OVH_UPPER) begin
        ovhUpper_q <= avsWritedata[15:0];
      end else if (avsAddress == `OFS_OVH_LOWER) begin
        ovhLower_q <= avsWritedata[15:0];
      end
    end
  end

  // sticky temperature status, write one to clear, assertion wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      intSticky_q <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == 0) ? dieRise : ovhRise) begin
          intSticky_q[b] <= 1'b1;
        end else if (wrFull && (avsAddress == `OFS_INT_STATUS) && avsWritedata[b]) begin
          intSticky_q[b] <= 1'b0;
        end
      end
    end
  end

  logic [2:0] intStatus;
  assign intStatus = {|alarmFlags_q, intSticky_q};

  // outputs to the system; the overheat line stays up until the reading
  // falls below the lower limit or shutdown is disabled, which is what holds the reboot off
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarmIrq      <= 1'b0;
      overheatToPmc <= 1'b0;
    end else begin
      alarmIrq      <= |(intStatus & intEnable_q);
      overheatToPmc <= ovhAlarm_q && shutdownEn_q;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    if (avsAddress == `OFS_CONFIG) begin
      rdMux = {27'h0, shutdownEn_q, 2'h0, level_q};
    end else if (avsAddress == `OFS_INT_STATUS) begin
      rdMux = {29'h0, intStatus};
    end else if (avsAddress == `OFS_INT_ENABLE) begin
      rdMux = {29'h0, intEnable_q};
    end else if (avsAddress == `OFS_TEMP_RESULT) begin
      rdMux = {16'h0, tempResult_q};
    end else if (avsAddress == `OFS_DIE_UPPER) begin
      rdMux = {16'h0, dieUpper_q};
    end else if (avsAddress == `OFS_DIE_LOWER) begin
      rdMux = {16'h0, dieLower_q};
    end else if (avsAddress == `OFS_OVH_UPPER) begin
      rdMux = {16'h0, ovhUpper_q};
    end else if (avsAddress == `OFS_OVH_LOWER) begin
      rdMux = {16'h0, ovhLower_q};
    end else if (avsAddress == `OFS_TEMP_PEAK_HIGH) begin
      rdMux = {16'h0, tempPeakHigh_q};
    end else if (avsAddress == `OFS_TEMP_PEAK_LOW) begin
      rdMux = {16'h0, tempPeakLow_q};
    end else if (avsAddress == `OFS_ALARM_STATE) begin
      rdMux = {30'h0, ovhAlarm_q, dieAlarm_q};
    end else if (bankHit) begin
      if (bank == `BANK_RESULT) begin
        rdMux = {13'h0, result_q[wrIdx]};
      end else if (bank == `BANK_UPPER) begin
        rdMux = {13'h0, upper_q[wrIdx]};
      end else if (bank == `BANK_LOWER) begin
        rdMux = {13'h0, lower_q[wrIdx]};
      end else if (bank == `BANK_PEAK_HIGH) begin
        rdMux = {13'h0, peakHigh_q[wrIdx]};
      end else begin
        rdMux = {13'h0, peakLow_q[wrIdx]};
      end
    end else if (vecHit) begin
      if (vecSel == `VEC_AVG_ENABLE) begin
        rdMux = avgEnable_q[32 * wrWord +: 32];
      end else if (vecSel == `VEC_ALARM_ENABLE) begin
        rdMux = alarmEnable_q[32 * wrWord +: 32];
      end else if (vecSel == `VEC_ALARM_FLAGS) begin
        rdMux = alarmFlags_q[32 * wrWord +: 32];
      end
    end
  end

  // captured in the wait cycle, shown while waitrequest is low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      avsReaddata <= 32'h0;
    end else if (rdTake) begin
      avsReaddata <= rdMux;
    end
  end
endmodule : monitor_channel_postprocess

// ### bench/monitor_postprocess_chk.sv
// port-level assertion checker of the monitor post-processor
`timescale 1ns/1ps
module monitor_postprocess_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // register bus
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsReaddata,
  input wire logic        avsWaitrequest,
  // streams and outputs
  input wire logic        sampleValid,
  input wire logic        tempValid,
  input wire logic        overheatToPmc,
  input wire logic        alarmIrq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // bus timing: writes are free, reads pay exactly one stall
  property p_wrFree; avsWrite |-> !avsWaitrequest; endproperty
  a_wrFree: assert property (p_wrFree) else $error("write stalled");
  property p_idle; !avsRead |-> !avsWaitrequest; endproperty
  a_idle: assert property (p_idle) else $error("stall without read");
  property p_rdWait; $rose(avsRead) |-> avsWaitrequest ##1 !avsWaitrequest; endproperty
  a_rdWait: assert property (p_rdWait) else $error("read stall length");
  // read data only moves on a capture edge
  property p_rdHold; !(avsRead && avsWaitrequest) |=> $stable(avsReaddata); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
  // outputs follow their cause by two edges, never spontaneously
  property p_ovhRise;
    $rose(overheatToPmc) |-> $past(tempValid, 2) || $past(avsWrite, 2);
  endproperty
  a_ovhRise: assert property (p_ovhRise) else $error("overheat rose alone");
  property p_ovhFall;
    $fell(overheatToPmc) |-> $past(tempValid, 2) || $past(avsWrite, 2);
  endproperty
  a_ovhFall: assert property (p_ovhFall) else $error("overheat fell alone");
  property p_irqRise;
    $rose(alarmIrq) |-> $past(sampleValid, 2) || $past(tempValid, 2) || $past(avsWrite, 2);
  endproperty
  a_irqRise: assert property (p_irqRise) else $error("irq rose alone");
  // sticky flags: only software can drop the interrupt
  property p_irqFall; $fell(alarmIrq) |-> $past(avsWrite, 2); endproperty
  a_irqFall: assert property (p_irqFall) else $error("irq fell alone");
endmodule : monitor_postprocess_chk

// ### bench/adc_pmc_model.sv
// sample source and platform controller model
`timescale 1ns/1ps
module adc_pmc_model (
  // clock
  input  wire logic        core_clk,
  // sample streams
  output logic             sampleValid,
  output logic [7:0]       sampleChannel,
  output logic [18:0]      sampleData,
  output logic             tempValid,
  output logic [15:0]      tempData,
  // controller side
  input  wire logic        overheatToPmc,
  output logic             rebootHeld
);
  initial begin
    sampleValid = 1'b0;
    sampleChannel = 8'h00;
    sampleData = 19'h00000;
    tempValid = 1'b0;
    tempData = 16'h0000;
  end
  // boot is held off for as long as the overheat line stands
  always_ff @(posedge core_clk) rebootHeld <= overheatToPmc;
  // idle data is inverted so a stale value is never mistaken for a sample
  task automatic volt(input logic [7:0] ch, input logic [18:0] d);
    @(posedge core_clk);
    sampleValid <= 1'b1;
    sampleChannel <= ch;
    sampleData <= d;
    @(posedge core_clk);
    sampleValid <= 1'b0;
    sampleData <= ~d;
  endtask : volt
  task automatic temp(input logic [15:0] d);
    @(posedge core_clk);
    tempValid <= 1'b1;
    tempData <= d;
    @(posedge core_clk);
    tempValid <= 1'b0;
    tempData <= ~d;
  endtask : temp
endmodule : adc_pmc_model

// ### bench/monitor_channel_postprocess_tb.sv
// self-checking bench of the monitor post-processor
`timescale 1ns/1ps
module monitor_channel_postprocess_tb;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [13:0] avsAddress = 14'h0000;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0]  avsByteenable = 4'hf;
  logic [31:0] avsReaddata, rnd, prev;
  logic        avsWaitrequest, sampleValid, tempValid, overheatToPmc, alarmIrq, rebootHeld;
  logic [7:0]  sampleChannel;
  logic [18:0] sampleData, hi, lo;
  logic [15:0] tempData;
  logic [23:0] sum;
  logic [31:0] expQ[$];
  int          errTotal = 0;
  int          testsRun = 0;
  int          cycles = 0;
  always #12.5 core_clk = ~core_clk;
  monitor_channel_postprocess monitor_channel_postprocess_i (.core_clk(core_clk),
    .rst_b(rst_b), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .sampleValid(sampleValid),
    .sampleChannel(sampleChannel), .sampleData(sampleData), .tempValid(tempValid),
    .tempData(tempData), .overheatToPmc(overheatToPmc), .alarmIrq(alarmIrq));
  adc_pmc_model adc_pmc_model_i (.core_clk(core_clk), .sampleValid(sampleValid),
    .sampleChannel(sampleChannel), .sampleData(sampleData), .tempValid(tempValid),
    .tempData(tempData), .overheatToPmc(overheatToPmc), .rebootHeld(rebootHeld));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic fail(input string m);
    errTotal++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic finalReport();
    if (errTotal == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finalReport
  // hold the request until waitrequest is seen low at an edge;
  // a slave that never answers is caught by the cycle ceiling
  task automatic waitAns();
    do begin
      @(posedge core_clk);
    end while (avsWaitrequest !== 1'b0);
  endtask : waitAns
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= 1'b1;
    waitAns();
    avsWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [13:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge core_clk);
    avsAddress <= a;
    avsRead <= 1'b1;
    waitAns();
    avsRead <= 1'b0;
  endtask : rd
  task automatic pin(input logic g, input logic e);
    testsRun++;
    if (g !== e) fail("output pin");
  endtask : pin
  // scoreboard: oldest note against each completed read
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail("timeout");
      finalReport();
    end else if (avsRead === 1'b1 && avsWaitrequest === 1'b0) begin
      testsRun++;
      if (expQ.size() == 0 || avsReaddata !== expQ[0]) fail("read data");
      if (expQ.size() != 0) void'(expQ.pop_front());
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values, last channel and an unmapped place
    rd(14'h0000, 32'h0);
    // a partial-word write must leave the threshold alone
    avsByteenable <= 4'h3;
    wr(14'h0010, 32'h1234);
    avsByteenable <= 4'hf;
    rd(14'h0010, 32'h2800);
    rd(14'h001c, 32'h2d00);
    rd(14'h167c, 32'h7ffff);
    wr(14'h3ffc, 32'h5);
    rd(14'h3ffc, 32'h0);
    // plain channel keeps its extremes from the first value on
    hi = 19'h0;
    lo = 19'h7ffff;
    rnd = 32'h0175;
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      adc_pmc_model_i.volt(8'h05, rnd[18:0]);
      if (rnd[18:0] > hi) hi = rnd[18:0];
      if (rnd[18:0] < lo) lo = rnd[18:0];
    end
    rd(14'h1014, {13'h0, rnd[18:0]});
    rd(14'h1c14, {13'h0, hi});
    rd(14'h2014, {13'h0, lo});
    // every shared level on an averaged channel beside a plain one
    prev = 32'h0;
    wr(14'h2400, 32'h8);
    for (int l = 0; l < 4; l++) begin
      wr(14'h0000, l);
      wr(14'h2460, 32'h8);
      sum = 24'h0;
      for (int s = 0; s < (2 << l); s++) begin
        rnd = lfsr(rnd);
        sum += rnd[18:0];
        adc_pmc_model_i.volt(8'h03, rnd[18:0]);
        if (s == 0) adc_pmc_model_i.volt(8'h04, rnd[18:0]);
        if (s == 0) rd(14'h1010, {13'h0, rnd[18:0]});
        if (s == (2 << l) - 2) rd(14'h100c, prev);
      end
      prev = {8'h0, sum >> (l + 1)};
      rd(14'h100c, prev);
      rd(14'h1c0c, prev);
      rd(14'h200c, prev);
    end
    rd(14'h1c14, {13'h0, hi});
    // window alarm on channel 7, flag and interrupt
    wr(14'h141c, 32'h3e8);
    wr(14'h181c, 32'h64);
    wr(14'h2420, 32'h80);
    wr(14'h0008, 32'h4);
    adc_pmc_model_i.volt(8'h07, 19'h1f4);
    rd(14'h2440, 32'h0);
    pin(alarmIrq, 1'b0);
    adc_pmc_model_i.volt(8'h07, 19'h7d0);
    rd(14'h2440, 32'h80);
    pin(alarmIrq, 1'b1);
    wr(14'h2440, 32'h80);
    rd(14'h0004, 32'h0);
    pin(alarmIrq, 1'b0);
    adc_pmc_model_i.volt(8'h07, 19'h32);
    rd(14'h2440, 32'h80);
    wr(14'h2440, 32'h80);
    // temperature: fixed eight-sample average and hysteresis
    wr(14'h0000, 32'h10);
    repeat (7) adc_pmc_model_i.temp(16'h3300);
    rd(14'h0028, 32'h0);
    adc_pmc_model_i.temp(16'h3300);
    rd(14'h000c, 32'h3300);
    rd(14'h0028, 32'h3);
    rd(14'h0004, 32'h3);
    pin(overheatToPmc, 1'b1);
    pin(rebootHeld, 1'b1);
    // temperature status reaches the interrupt and clears by write one
    wr(14'h0008, 32'h2);
    rd(14'h0008, 32'h2);
    pin(alarmIrq, 1'b1);
    wr(14'h0004, 32'h3);
    rd(14'h0004, 32'h0);
    pin(alarmIrq, 1'b0);
    // without shutdown enabled the controller is not told
    wr(14'h0000, 32'h0);
    rd(14'h0000, 32'h0);
    pin(overheatToPmc, 1'b0);
    wr(14'h0000, 32'h10);
    repeat (8) adc_pmc_model_i.temp(16'h2e00);
    rd(14'h0028, 32'h3);
    repeat (8) adc_pmc_model_i.temp(16'hff00);
    rd(14'h0028, 32'h0);
    rd(14'h0024, 32'hff00);
    pin(overheatToPmc, 1'b0);
    repeat (3) @(posedge core_clk);
    finalReport();
  end
endmodule : monitor_channel_postprocess_tb
bind monitor_channel_postprocess monitor_postprocess_chk monitor_postprocess_chk_i (
  .core_clk(core_clk), .rst_b(rst_b), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .sampleValid(sampleValid),
  .tempValid(tempValid), .overheatToPmc(overheatToPmc), .alarmIrq(alarmIrq));
